// [sep_map.svh]
`ifndef SEP_MAP_SVH
`define SEP_MAP_SVH
// system clock rate and self-timed cycle limits
`define SEP_CLK_MHZ 20
`define SEP_T_WRITE_US 2000
`define SEP_T_ERASE_US 1000
`define SEP_T_ALL_US 15000
// array geometry
`define SEP_ADDR_W 6
`define SEP_DATA_W 16
`define SEP_TMR_W 19
`define SEP_ADDR_LAST 6'h3f
`define SEP_ERASED 16'hffff
// frame bit counts, as last index of each input phase; read as a full bit count
`define SEP_OPC_LAST 5'h01
`define SEP_ADR_LAST 5'h05
`define SEP_DAT_LAST 5'h0f
`define SEP_RD_BITS 5'h10
// opcode and special command codes
`define SEP_OPC_SPECIAL 2'h0
`define SEP_OPC_WRITE 2'h1
`define SEP_OPC_READ 2'h2
`define SEP_OPC_ERASE 2'h3
`define SEP_SP_EN 2'h3
`define SEP_SP_DIS 2'h0
`define SEP_SP_ERASE_ALL_CMD 2'h2
`define SEP_SP_WRITE_ALL_CMD 2'h1
`endif

// [sep_pkg.sv]
`include "sep_map.svh"
package sep_pkg;
  typedef enum logic [1:0] {
    SEP_OP_SPECIAL = `SEP_OPC_SPECIAL,
    SEP_OP_WRITE = `SEP_OPC_WRITE,
    SEP_OP_READ = `SEP_OPC_READ,
    SEP_OP_ERASE = `SEP_OPC_ERASE
  } sep_op_e;
  // gray codes along idle-opcode-address-data-done
  typedef enum logic [2:0] {
    SEP_ST_IDLE = 3'h0,
    SEP_ST_OPC = 3'h1,
    SEP_ST_ADR = 3'h3,
    SEP_ST_DAT = 3'h2,
    SEP_ST_DONE = 3'h6,
    SEP_ST_RD = 3'h7
  } sep_st_e;
  typedef enum logic [1:0] {
    SEP_JOB_WRITE = 2'h0,
    SEP_JOB_ERASE = 2'h1,
    SEP_JOB_ERASE_ALL_CMD = 2'h2,
    SEP_JOB_WRITE_ALL_CMD = 2'h3
  } sep_job_e;
  typedef logic [`SEP_TMR_W-1:0] sep_tmr_t;
  typedef logic [`SEP_ADDR_W-1:0] sep_addr_t;
  typedef logic [`SEP_DATA_W-1:0] sep_data_t;
  typedef struct packed {
    sep_job_e kind;
    sep_addr_t addr;
    sep_data_t data;
  } sep_job_s;
endpackage : sep_pkg

// [sep_mem.sv]
`timescale 1ns/1ps
`include "sep_map.svh"
module sep_mem (
  // clock
  input wire logic clk_sys,
  // write port
  input wire logic wr_en,
  input wire sep_pkg::sep_addr_t wr_addr,
  input wire sep_pkg::sep_data_t wr_data,
  // read port, data one cycle after address
  input wire sep_pkg::sep_addr_t rd_addr,
  output sep_pkg::sep_data_t rd_data_ff
);
  import sep_pkg::*;
  sep_data_t mem [0:(1 << `SEP_ADDR_W) - 1];

  // array write; no reset, contents are nonvolatile by intent
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read
  always_ff @(posedge clk_sys)
  begin
    rd_data_ff <= mem[rd_addr];
  end
endmodule : sep_mem

// [sep_cmd_port.sv]
`timescale 1ns/1ps
`include "sep_map.svh"
// Overview of operation
// - start bit is first sampled clock edge with select and serial_in high.
// - nothing happens before a start bit; select high leaves standby.
// - commands execute only after their full bit count arrives.
// - after the last bit, clock and input are ignored until a new start.
// - opcode 10 read, 01 write, 11 erase, 00 special; 25 or 9 clocks.
// - special uses two upper address bits: 11 en, 00 dis, 10 erase_all_cmd, 01 write_all_cmd.
// - 16-word variant pads two leading zeros; 64-word uses all six bits.
// - read outputs a dummy zero, then 16 data bits msb first.
// - read bits change after rising edge; dummy follows the last address edge.
// - output floats at edge after last bit, or when select falls.
// - read bit is held while select stays high, however long.
// - write takes 16 bits msb first, then self-timed erase and program.
// - single word write cycle ends within 2 ms.
// - erase sets word to ones, self-timed, within 1 ms.
// - program-disabled after power-up; program commands refused until enabled.
// - erase-all sets array to ones within 15 ms when enabled.
// - write-all programs every word with data, no erase, within 15 ms.
// - ready/busy appears only when select is re-raised during a cycle.
// - bits sampled and output updated on serial clock rising edge.
// - select low resets command logic; running cycle completes.
// - any clocks before a start bit change nothing.
module sep_cmd_port #(
  parameter int T_WRITE_CYC = `SEP_T_WRITE_US * `SEP_CLK_MHZ,
  parameter int T_ERASE_CYC = `SEP_T_ERASE_US * `SEP_CLK_MHZ,
  parameter int T_ALL_CYC = `SEP_T_ALL_US * `SEP_CLK_MHZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // serial pins from the host
  input wire logic select,
  input wire logic sclk,
  input wire logic serial_in,
  // serial output pin, three-state
  output logic serial_out,
  output logic serial_out_oe
);
  import sep_pkg::*;

  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic sclk_prev_ff;
  logic sel_prev_ff;
  logic sel_s;
  logic sclk_s;
  logic di_s;
  logic sclk_rise;
  logic sel_rise;
  sep_st_e st_ff;
  logic [4:0] cnt_ff;
  sep_op_e op_ff;
  sep_addr_t addr_ff;
  sep_data_t data_ff;
  sep_data_t shreg_ff;
  logic so_ff;
  logic rd_oe_ff;
  logic rd_req_ff;
  logic rd_load_ff;
  sep_addr_t rd_addr_ff;
  logic prog_en_ff;
  logic stat_en_ff;
  logic rdy_ff;
  sep_addr_t addr_full;
  sep_data_t data_full;
  logic last_adr;
  logic last_dat;
  logic exec_valid;
  sep_job_s exec_job;
  logic pend_ff;
  sep_job_s pend_job_ff;
  sep_job_s ent_ff [0:1];
  logic [1:0] fifo_cnt_ff;
  logic fifo_in_ready;
  logic fifo_push;
  logic fifo_pop;
  logic eng_run_ff;
  sep_job_s eng_job_ff;
  sep_tmr_t tmr_ff;
  logic wr_act_ff;
  sep_addr_t wr_addr_ff;
  sep_data_t mem_wdata;
  sep_data_t mem_rdata;
  logic busy;

  // whole-array jobs walk every address
  function automatic logic is_all(input sep_job_e k);
    is_all = (k == SEP_JOB_ERASE_ALL_CMD) || (k == SEP_JOB_WRITE_ALL_CMD);
  endfunction : is_all

  // cycle budget per job, loaded as count minus one
  function automatic sep_tmr_t tmr_load(input sep_job_e k);
    unique case (k)
      SEP_JOB_WRITE: tmr_load = sep_tmr_t'(T_WRITE_CYC - 1);
      SEP_JOB_ERASE: tmr_load = sep_tmr_t'(T_ERASE_CYC - 1);
      SEP_JOB_ERASE_ALL_CMD,
      SEP_JOB_WRITE_ALL_CMD: tmr_load = sep_tmr_t'(T_ALL_CYC - 1);
    endcase
  endfunction : tmr_load

  // two-stage synchronisers for the asynchronous pins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= {select, sclk, serial_in};
      sync2_ff <= sync1_ff;
    end
  end

  // edge history, read only from the second stage
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sclk_prev_ff <= 1'b0;
      sel_prev_ff <= 1'b0;
    end
    else
    begin
      sclk_prev_ff <= sync2_ff[1];
      sel_prev_ff <= sync2_ff[2];
    end
  end

  assign sel_s = sync2_ff[2];
  assign sclk_s = sync2_ff[1];
  assign di_s = sync2_ff[0];
  assign sclk_rise = sclk_s & ~sclk_prev_ff;
  assign sel_rise = sel_s & ~sel_prev_ff;

  // shift views including the bit sampled on this edge
  assign addr_full = {addr_ff[`SEP_ADDR_W-2:0], di_s};
  assign data_full = {data_ff[`SEP_DATA_W-2:0], di_s};
  assign last_adr = sel_s && sclk_rise && st_ff == SEP_ST_ADR && cnt_ff == `SEP_ADR_LAST;
  assign last_dat = sel_s && sclk_rise && st_ff == SEP_ST_DAT && cnt_ff == `SEP_DAT_LAST;

  // frame sequencer; select low holds it in reset
  always_ff @(posedge clk_sys)
  begin
    if (reset || !sel_s)
    begin
      st_ff <= SEP_ST_IDLE;
      cnt_ff <= 5'h00;
      op_ff <= SEP_OP_SPECIAL;
      addr_ff <= '0;
      data_ff <= '0;
      so_ff <= 1'b0;
      rd_oe_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      rd_addr_ff <= '0;
    end
    else
    begin
      rd_req_ff <= 1'b0;
      if (sclk_rise)
      begin
        unique case (st_ff)
          SEP_ST_IDLE:
          begin
            if (di_s)
            begin
              st_ff <= SEP_ST_OPC;
              cnt_ff <= 5'h00;
            end
          end
          SEP_ST_OPC:
          begin
            op_ff <= sep_op_e'({op_ff[0], di_s});
            cnt_ff <= (cnt_ff == `SEP_OPC_LAST) ? 5'h00 : cnt_ff + 5'h01;
            if (cnt_ff == `SEP_OPC_LAST)
            begin
              st_ff <= SEP_ST_ADR;
            end
          end
          SEP_ST_ADR:
          begin
            addr_ff <= addr_full;
            cnt_ff <= (cnt_ff == `SEP_ADR_LAST) ? 5'h00 : cnt_ff + 5'h01;
            if (cnt_ff == `SEP_ADR_LAST)
            begin
              unique case (op_ff)
                SEP_OP_READ:
                begin
                  st_ff <= SEP_ST_RD;
                  so_ff <= 1'b0;
                  rd_oe_ff <= 1'b1;
                  rd_req_ff <= 1'b1;
                  rd_addr_ff <= addr_full;
                end
                SEP_OP_WRITE: st_ff <= SEP_ST_DAT;
                SEP_OP_SPECIAL:
                  st_ff <= (addr_full[`SEP_ADDR_W-1 -: 2] == `SEP_SP_WRITE_ALL_CMD) ? SEP_ST_DAT
                                                                           : SEP_ST_DONE;
                SEP_OP_ERASE: st_ff <= SEP_ST_DONE;
              endcase
            end
          end
          SEP_ST_DAT:
          begin
            data_ff <= data_full;
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == `SEP_DAT_LAST)
            begin
              st_ff <= SEP_ST_DONE;
            end
          end
          SEP_ST_RD:
          begin
            if (cnt_ff == `SEP_RD_BITS)
            begin
              rd_oe_ff <= 1'b0;
              st_ff <= SEP_ST_DONE;
            end
            else
            begin
              so_ff <= shreg_ff[`SEP_DATA_W-1];
              cnt_ff <= cnt_ff + 5'h01;
            end
          end
          SEP_ST_DONE: st_ff <= SEP_ST_DONE;
          default: st_ff <= SEP_ST_IDLE;
        endcase
      end
    end
  end

  // read shifter; word lands two cycles after the last address edge,
  // long before the next serial edge at the documented clock rate
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_load_ff <= 1'b0;
      shreg_ff <= '0;
    end
    else
    begin
      rd_load_ff <= rd_req_ff;
      if (rd_load_ff)
      begin
        shreg_ff <= mem_rdata;
      end
      else if (sel_s && sclk_rise && st_ff == SEP_ST_RD && cnt_ff != `SEP_RD_BITS)
      begin
        shreg_ff <= {shreg_ff[`SEP_DATA_W-2:0], 1'b0};
      end
    end
  end

  // program enable latch; takes effect at the ninth edge
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prog_en_ff <= 1'b0;
    end
    else if (last_adr && op_ff == SEP_OP_SPECIAL)
    begin
      if (addr_full[`SEP_ADDR_W-1 -: 2] == `SEP_SP_EN)
      begin
        prog_en_ff <= 1'b1;
      end
      else if (addr_full[`SEP_ADDR_W-1 -: 2] == `SEP_SP_DIS)
      begin
        prog_en_ff <= 1'b0;
      end
    end
  end

  // job decode at the final required bit
  always_comb
  begin
    exec_job = '{kind: SEP_JOB_WRITE, addr: addr_full, data: data_full};
    exec_valid = 1'b0;
    if (last_adr && op_ff == SEP_OP_ERASE)
    begin
      exec_job.kind = SEP_JOB_ERASE;
      exec_valid = 1'b1;
    end
    else if (last_adr && op_ff == SEP_OP_SPECIAL
             && addr_full[`SEP_ADDR_W-1 -: 2] == `SEP_SP_ERASE_ALL_CMD)
    begin
      exec_job.kind = SEP_JOB_ERASE_ALL_CMD;
      exec_valid = 1'b1;
    end
    else if (last_dat)
    begin
      exec_job.kind = (op_ff == SEP_OP_WRITE) ? SEP_JOB_WRITE : SEP_JOB_WRITE_ALL_CMD;
      exec_job.addr = addr_ff;
      exec_valid = 1'b1;
    end
    // disabled or stalled jobs vanish without any busy indication
    exec_valid = exec_valid && prog_en_ff && !pend_ff;
  end

  // pending job waits here while the buffer is full
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pend_ff <= 1'b0;
      pend_job_ff <= '0;
    end
    else if (exec_valid)
    begin
      pend_ff <= 1'b1;
      pend_job_ff <= exec_job;
    end
    else if (fifo_push)
    begin
      pend_ff <= 1'b0;
    end
  end

  assign fifo_in_ready = (fifo_cnt_ff != 2'h2);
  assign fifo_push = pend_ff && fifo_in_ready;
  assign fifo_pop = (fifo_cnt_ff != 2'h0) && !eng_run_ff;

  // two-entry job buffer; engine stall backs up into the pending slot
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      fifo_cnt_ff <= 2'h0;
      ent_ff[0] <= '0;
      ent_ff[1] <= '0;
    end
    else
    begin
      fifo_cnt_ff <= fifo_cnt_ff + {1'b0, fifo_push} - {1'b0, fifo_pop};
      if (fifo_pop)
      begin
        ent_ff[0] <= ent_ff[1];
      end
      if (fifo_push && (fifo_cnt_ff == 2'h0 || (fifo_cnt_ff == 2'h1 && fifo_pop)))
      begin
        ent_ff[0] <= pend_job_ff;
      end
      else if (fifo_push)
      begin
        ent_ff[1] <= pend_job_ff;
      end
    end
  end

  // self-timed engine; array writes finish well inside the budget
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      eng_run_ff <= 1'b0;
      eng_job_ff <= '0;
      tmr_ff <= '0;
      wr_act_ff <= 1'b0;
      wr_addr_ff <= '0;
    end
    else if (fifo_pop)
    begin
      eng_run_ff <= 1'b1;
      eng_job_ff <= ent_ff[0];
      wr_act_ff <= 1'b1;
      wr_addr_ff <= is_all(ent_ff[0].kind) ? '0 : ent_ff[0].addr;
      tmr_ff <= tmr_load(ent_ff[0].kind);
    end
    else if (eng_run_ff)
    begin
      if (wr_act_ff && (!is_all(eng_job_ff.kind) || wr_addr_ff == `SEP_ADDR_LAST))
      begin
        wr_act_ff <= 1'b0;
      end
      else if (wr_act_ff)
      begin
        wr_addr_ff <= wr_addr_ff + 1'b1;
      end
      if (tmr_ff == '0)
      begin
        eng_run_ff <= 1'b0;
      end
      else
      begin
        tmr_ff <= tmr_ff - 1'b1;
      end
    end
  end

  // erase kinds store ones; write stores data, erase folded in
  assign mem_wdata = (eng_job_ff.kind == SEP_JOB_ERASE || eng_job_ff.kind == SEP_JOB_ERASE_ALL_CMD)
                     ? `SEP_ERASED : eng_job_ff.data;

  sep_mem i_sep_mem (
    .clk_sys(clk_sys),
    .wr_en(wr_act_ff),
    .wr_addr(wr_addr_ff),
    .wr_data(mem_wdata),
    .rd_addr(rd_addr_ff),
    .rd_data_ff(mem_rdata)
  );

  assign busy = pend_ff || (fifo_cnt_ff != 2'h0) || eng_run_ff;

  // status shows only after select is re-raised while busy
  always_ff @(posedge clk_sys)
  begin
    if (reset || !sel_s)
    begin
      stat_en_ff <= 1'b0;
    end
    else if (sel_rise && busy)
    begin
      stat_en_ff <= 1'b1;
    end
    else if (sclk_rise && di_s && st_ff == SEP_ST_IDLE)
    begin
      stat_en_ff <= 1'b0;
    end
  end

  // ready level, registered
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rdy_ff <= 1'b1;
    end
    else
    begin
      rdy_ff <= !busy;
    end
  end

  assign serial_out = stat_en_ff ? rdy_ff : so_ff;
  assign serial_out_oe = stat_en_ff | rd_oe_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_start;
    st_ff == SEP_ST_IDLE && sel_s && sclk_rise && di_s;
  endsequence
  sequence s_a0_read;
    last_adr && op_ff == SEP_OP_READ;
  endsequence
  sequence s_write_pop;
    fifo_pop && ent_ff[0].kind == SEP_JOB_WRITE;
  endsequence

  property p_start;
    s_start |=> st_ff == SEP_ST_OPC && cnt_ff == 5'h00;
  endproperty
  a_start: assert property (p_start) else $error("start bit missed");

  property p_idle_quiet;
    st_ff == SEP_ST_IDLE && !(sel_s && sclk_rise && di_s)
      |=> st_ff == SEP_ST_IDLE && $stable(prog_en_ff);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle state changed");

  property p_desel;
    !sel_s |=> st_ff == SEP_ST_IDLE && !serial_out_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect did not reset");

  property p_done_hold;
    st_ff == SEP_ST_DONE && sel_s |=> st_ff == SEP_ST_DONE;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("left done while selected");

  property p_dummy;
    s_a0_read |=> serial_out_oe && !so_ff ##1 !$changed(so_ff);
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy zero wrong");

  property p_float;
    st_ff == SEP_ST_RD && sel_s && sclk_rise && cnt_ff == `SEP_RD_BITS |=> !rd_oe_ff;
  endproperty
  a_float: assert property (p_float) else $error("output not floated");

  property p_rd_hold;
    st_ff == SEP_ST_RD && sel_s && !sclk_rise |=> $stable(so_ff) && rd_oe_ff;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read bit moved");

  property p_refuse;
    !prog_en_ff && !busy |=> !busy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("busy while disabled");

  property p_write_mem;
    s_write_pop |=> wr_act_ff && mem_wdata == $past(ent_ff[0].data);
  endproperty
  a_write_mem: assert property (p_write_mem) else $error("write data lost");

  property p_erase_time;
    fifo_pop && ent_ff[0].kind == SEP_JOB_ERASE |=> tmr_ff == sep_tmr_t'(T_ERASE_CYC - 1);
  endproperty
  a_erase_time: assert property (p_erase_time) else $error("erase budget wrong");

  property p_status;
    stat_en_ff ##1 stat_en_ff |-> serial_out == !$past(busy);
  endproperty
  a_status: assert property (p_status) else $error("ready level wrong");
endmodule : sep_cmd_port

// [sep_host.sv]
`timescale 1ns/1ps
`include "sep_map.svh"
module sep_host (
  // clock
  input wire logic clk_sys,
  // pins toward the port
  output logic select,
  output logic sclk,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  // observations for the bench
  output logic res_valid,
  output logic [18:0] res_word
);
  // released line reads high through the pull-up
  // separate wires here, so the dummy zero never fights a high A0
  wire do_lvl = serial_out_oe ? serial_out : 1'b1;

  // idle pins at time zero: clock stands still outside frames
  initial
  begin
    select = 1'b0;
    sclk = 1'b0;
    serial_in = 1'b0;
    res_valid = 1'b0;
    res_word = '0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // one-cycle strobe so the bench sees each result once
  task automatic post(input logic [18:0] w);
    tick(1);
    res_word = w;
    res_valid = 1'b1;
    tick(1);
    res_valid = 1'b0;
  endtask : post

  // 500 ns low then 500 ns high; output is looked at just before the rise
  task automatic rise(input logic b, output logic d, output logic e);
    serial_in = b;
    tick(10);
    d = do_lvl;
    e = serial_out_oe;
    sclk = 1'b1;
    tick(10);
    sclk = 1'b0;
  endtask : rise

  // frame of nr rises after three idle clocks; reads report what came out
  task automatic cmd(input logic [8:0] hdr, input logic [15:0] dat, input int nr);
    logic [24:0] bits;
    logic [18:0] w;
    logic d;
    logic e;
    bits = {hdr, dat};
    w = '0;
    select = 1'b1;
    for (int i = 0; i < 3; i++)
      rise(1'b0, d, e);
    for (int i = 0; i < nr; i++)
    begin
      rise(i < 25 ? bits[24 - i] : 1'b1, d, e);
      if (i == 9)
        w[18:17] = {e, d};
      if (i > 9 && i < 26)
        w[26 - i] = d;
      if (i == 26)
        w[0] = e;
    end
    tick(10);
    // a full read must already have released the output before select falls
    if (nr > 26)
      w[0] = w[0] | serial_out_oe;
    select = 1'b0;
    tick(4);
    w[0] = w[0] | serial_out_oe;
    if (nr < 27)
      w[18:1] = '0;
    if (hdr[7:6] == `SEP_OPC_READ)
      post(w);
  endtask : cmd

  // raise select and watch status, waiting up to cyc clocks for ready
  task automatic stat(input int cyc);
    serial_in = 1'b0;
    select = 1'b1;
    tick(6);
    for (int k = 0; k < cyc && do_lvl !== 1'b1; k++)
      tick(1);
    post({serial_out_oe, do_lvl, 17'h0});
    select = 1'b0;
    tick(4);
  endtask : stat
endmodule : sep_host

// [sep_cmd_port_tb_top.sv]
`timescale 1ns/1ps
`include "sep_map.svh"
`define SEP_CHK(nm, ex, ac) \
  begin \
    check_count++; \
    if ((ex) !== (ac)) \
    begin \
      error_cnt++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, ac); \
    end \
  end
module sep_cmd_port_tb_top;
  import sep_pkg::*;
  localparam int TW = 200;
  localparam int TE = 100;
  localparam int TA = 300;
  localparam logic [1:0] BUSY = 2'b10;
  localparam logic [1:0] RDY = 2'b11;
  localparam logic [1:0] NONE = 2'b01;
  typedef struct {
    string nm;
    logic [18:0] ex;
  } sep_note_s;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  wire logic select, sclk, serial_in, serial_out, serial_out_oe, res_valid;
  wire logic [18:0] res_word;
  int error_cnt = 0;
  int check_count = 0;
  int cyc_cnt = 0;
  sep_note_s note_q[$];
  sep_note_s n;
  logic [31:0] seed = 32'h00018483;

  always #25 clk_sys = ~clk_sys;

  sep_cmd_port #(.T_WRITE_CYC(TW), .T_ERASE_CYC(TE), .T_ALL_CYC(TA)) i_sep_cmd_port (
    .clk_sys(clk_sys), .reset(reset), .select(select), .sclk(sclk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  sep_host i_sep_host (
    .clk_sys(clk_sys), .select(select), .sclk(sclk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .res_valid(res_valid),
    .res_word(res_word));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic rnd16(output sep_data_t v);
    repeat (16) seed = lfsr(seed);
    v = seed[15:0];
  endtask : rnd16

  task automatic expect_res(input string nm, input logic [18:0] ex);
    note_q.push_back('{nm, ex});
  endtask : expect_res

  task automatic fr(input logic [1:0] op, input logic [5:0] a, input sep_data_t d, input int nr);
    i_sep_host.cmd({1'b1, op, a}, d, nr);
  endtask : fr

  // special commands get a random don't-care nibble
  task automatic sp(input logic [1:0] code, input sep_data_t d, input int nr);
    seed = lfsr(seed);
    fr(`SEP_OPC_SPECIAL, {code, seed[3:0]}, d, nr);
  endtask : sp

  // oe with dummy zero, sixteen bits, then released after the last one
  task automatic rd(input logic [5:0] a, input sep_data_t d);
    seed = lfsr(seed);
    expect_res("read word", {2'b10, d, 1'b0});
    fr(`SEP_OPC_READ, a, seed[15:0], 27);
  endtask : rd

  task automatic st(input string nm, input logic [1:0] ex, input int cyc);
    expect_res(nm, {ex, 17'h0});
    i_sep_host.stat(cyc);
  endtask : st

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done

  task print_verdict;
    // a note never answered means a result went missing
    `SEP_CHK("results left", 0, note_q.size())
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // oldest note is matched against each reported result
  always @(posedge clk_sys)
    if (res_valid === 1'b1)
    begin
      if (note_q.size() == 0)
        `SEP_CHK("unexpected result", 19'h0, res_word)
      else
      begin
        n = note_q.pop_front();
        `SEP_CHK(n.nm, n.ex, res_word)
      end
    end

  // a hang ends the run as a mismatch
  always @(posedge clk_sys)
  begin
    cyc_cnt++;
    if (cyc_cnt == 40000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  initial
  begin
    sep_data_t d;
    sep_data_t d0;
    repeat (6) @(posedge clk_sys);
    #1 reset = 1'b0;
    // program commands are dropped until enabled
    fr(`SEP_OPC_WRITE, 6'h05, 16'h1234, 25);
    st("refused write", NONE, 0);
    sp(`SEP_SP_ERASE_ALL_CMD, 16'h0, 9);
    st("refused erase-all", NONE, 0);
    done("protect");
    sp(`SEP_SP_EN, 16'h0, 9);
    sp(`SEP_SP_ERASE_ALL_CMD, 16'h0, 9);
    st("erase-all busy", BUSY, 0);
    st("erase-all ready", RDY, TA + 100);
    rd(6'h00, 16'hffff);
    rd(6'h3f, 16'hffff);
    done("erase all");
    // back to back writes, the first one finishes before the second frame ends
    rnd16(d0);
    rnd16(d);
    fr(`SEP_OPC_WRITE, 6'h00, d0, 25);
    fr(`SEP_OPC_WRITE, 6'h3f, d, 25);
    st("write busy", BUSY, 0);
    st("write ready", RDY, 2 * TW + 40);
    rd(6'h00, d0);
    rd(6'h3f, d);
    done("write");
    fr(`SEP_OPC_ERASE, 6'h3f, d, 9);
    st("erase busy", BUSY, 0);
    st("erase ready", RDY, TE + 20);
    rd(6'h3f, 16'hffff);
    done("erase");
    // frames cut short must leave everything alone
    fr(`SEP_OPC_WRITE, 6'h00, ~d0, 20);
    st("cut write", NONE, 0);
    rd(6'h00, d0);
    expect_res("cut read oe", 19'h0);
    fr(`SEP_OPC_READ, 6'h00, d0, 15);
    done("abort");
    // write-all only after a fresh erase-all
    sp(`SEP_SP_ERASE_ALL_CMD, 16'h0, 9);
    st("erase-all busy", BUSY, 0);
    st("erase-all ready", RDY, TA + 100);
    rnd16(d);
    sp(`SEP_SP_WRITE_ALL_CMD, d, 25);
    st("write-all busy", BUSY, 0);
    st("write-all ready", RDY, TA + 100);
    rd(6'h00, d);
    rd(6'h2a, d);
    rd(6'h3f, d);
    done("write all");
    // host locks programming again when finished
    sp(`SEP_SP_DIS, 16'h0, 9);
    fr(`SEP_OPC_WRITE, 6'h00, ~d, 25);
    st("locked write", NONE, 0);
    rd(6'h00, d);
    done("lock");
    repeat (4) @(posedge clk_sys);
    print_verdict();
  end
endmodule : sep_cmd_port_tb_top
